// file: hdl/filt_cfg_pkg.sv
// Purpose: Shared constants for the filter and low-power configuration block.
// Assumes: Classic Wishbone slave with 32-bit data, one register per word.
// Notes: Register indices are kept; byte address is four times the index.
package filt_cfg_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ACCEL_FILTER_CONFIG_IDX = 8'h1d;
    localparam logic [7:0] GYRO_LOW_POWER_CONFIG_IDX = 8'h1e;
    localparam logic [7:0] SAMPLE_RATE_DIVIDER_IDX = 8'h19;
    localparam logic [7:0] GYRO_BANDWIDTH_IDX = 8'h1a;
    localparam logic [7:0] CTRL_IDX = 8'h40;
    localparam logic [7:0] STATUS_IDX = 8'h41;
    localparam logic [7:0] ACCEL_FILTER_CONFIG_MASK = 8'h3f;
    localparam logic [7:0] GYRO_LOW_POWER_CONFIG_MASK = 8'hf0;
    localparam logic [7:0] ACCEL_FILTER_CONFIG_RST = 8'h00;
    localparam logic [7:0] GYRO_LOW_POWER_CONFIG_RST = 8'h00;
    localparam logic [7:0] SAMPLE_RATE_DIVIDER_RST = 8'h00;
    localparam logic [7:0] GYRO_BANDWIDTH_RST = 8'h00;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int ACCEL_AVG_LSB = 4;
    localparam int ACCEL_BYPASS_BIT = 3;
    localparam int GYRO_CYCLE_BIT = 7;
    localparam int GYRO_AVG_LSB = 4;
    localparam int CTRL_ACCEL_LP_BIT = 0;
    localparam int CTRL_RUN_BIT = 1;
    localparam logic [2:0] ACCEL_BW_AVG_CODE = 3'h7;
    // ----------------------------------------------------------------
    // Timing: base rate 1 kHz, base tick period in cycles.
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int BASE_RATE_HZ = 1_000;
    localparam int BASE_TICK_CYC = CLK_HZ / BASE_RATE_HZ;
    // On-times in microseconds, rounded down to cycles (longest times).
    localparam int ACCEL_TON_1X_US = 1084;
    localparam int ACCEL_TON_4X_US = 1840;
    localparam int ACCEL_TON_8X_US = 2840;
    localparam int ACCEL_TON_16X_US = 4840;
    localparam int ACCEL_TON_32X_US = 8840;
    localparam int GYRO_TON_BASE_US = 1730;
    localparam int GYRO_TON_1X_US = 1730;
    localparam int GYRO_TON_STEP_US = 500;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int TON_W = 24;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ON = 2'b01,
        PH_OFF = 2'b10
    } duty_phase_t;
endpackage

// file: hdl/rate_divider.sv
// Purpose: Divides a tick stream by one plus an 8-bit divider value.
// Assumes: Ticks arrive on the same clock, one cycle wide.
// Notes: A new divider value takes effect at once; the count is compared with it on every tick.
`timescale 1ns/1ns
module rate_divider (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic [7:0] div_i,
    input wire logic tick_i,
    // Output
    output logic strobe_o
);
    logic [7:0] cnt_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 8'h00;
        end else if (tick_i) begin
            if (cnt_r >= div_i) begin
                cnt_r <= 8'h00;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strobe_o <= 1'b0;
        end else begin
            strobe_o <= tick_i && (cnt_r >= div_i);
        end
    end
endmodule

// file: hdl/accel_gyro_filter_lowpower_cfg.sv
// Purpose: Filter and low-power averaging configuration for accel and gyro.
// Assumes: Classic Wishbone slave, 32-bit data, word-aligned registers.
// Notes: Accel filter settings are decoded to numeric outputs; the gyro bandwidth select passes through as a code.
`timescale 1ns/1ns
module accel_gyro_filter_lowpower_cfg (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Accelerometer filter settings
    output logic accel_filter_bypass_o,
    output logic [15:0] accel_bw_dhz_o,
    output logic [15:0] accel_rate_hz_o,
    output logic [5:0] accel_avg_samples_o,
    output logic accel_on_o,
    // Gyroscope filter settings
    output logic gyro_cycle_o,
    output logic [7:0] gyro_avg_samples_o,
    output logic [2:0] gyro_bandwidth_sel_o,
    output logic gyro_on_o,
    // Output data strobe
    output logic odr_strobe_o
);
    import filt_cfg_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] accel_filter_config_r;
    logic [7:0] gyro_low_power_config_r;
    logic [7:0] sample_rate_divider_r;
    logic [2:0] gyro_bandwidth_sel_r;
    logic [1:0] ctrl_r;
    logic [31:0] rd_nxt;
    logic hit_nxt;
    logic [7:0] idx;
    logic wr_en;
    logic [1:0] accel_avg_depth;
    logic accel_filter_bypass;
    logic [2:0] accel_bandwidth_sel;
    logic [2:0] gyro_avg_depth;
    logic accel_lp;
    logic run;

    assign idx = wb_adr_i[9:2];
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o && wb_sel_i[0];
    assign accel_avg_depth = accel_filter_config_r[ACCEL_AVG_LSB +: 2];
    assign accel_filter_bypass = accel_filter_config_r[ACCEL_BYPASS_BIT];
    assign accel_bandwidth_sel = accel_filter_config_r[2:0];
    assign gyro_avg_depth = gyro_low_power_config_r[GYRO_AVG_LSB +: 3];
    assign accel_lp = ctrl_r[CTRL_ACCEL_LP_BIT];
    assign run = ctrl_r[CTRL_RUN_BIT];

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    always_comb begin
        hit_nxt = 1'b1;
        rd_nxt = 32'h0000_0000;
        unique case (idx)
            ACCEL_FILTER_CONFIG_IDX: rd_nxt[7:0] = accel_filter_config_r;
            GYRO_LOW_POWER_CONFIG_IDX: rd_nxt[7:0] = gyro_low_power_config_r;
            SAMPLE_RATE_DIVIDER_IDX: rd_nxt[7:0] = sample_rate_divider_r;
            GYRO_BANDWIDTH_IDX: rd_nxt[2:0] = gyro_bandwidth_sel_r;
            CTRL_IDX: rd_nxt[1:0] = ctrl_r;
            STATUS_IDX: rd_nxt[2:0] = {odr_strobe_o, gyro_on_o, accel_on_o};
            default: hit_nxt = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Bus answer
    // ----------------------------------------------------------------
    // Answer one cycle after the request; drop the answer for a cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && hit_nxt;
            wb_err_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !hit_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= rd_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accel_filter_config_r <= ACCEL_FILTER_CONFIG_RST;
            gyro_low_power_config_r <= GYRO_LOW_POWER_CONFIG_RST;
            sample_rate_divider_r <= SAMPLE_RATE_DIVIDER_RST;
            gyro_bandwidth_sel_r <= GYRO_BANDWIDTH_RST[2:0];
            ctrl_r <= 2'b00;
        end else if (wr_en) begin
            unique case (idx)
                ACCEL_FILTER_CONFIG_IDX:
                    accel_filter_config_r <= wb_dat_i[7:0] & ACCEL_FILTER_CONFIG_MASK;
                GYRO_LOW_POWER_CONFIG_IDX:
                    gyro_low_power_config_r <= wb_dat_i[7:0] & GYRO_LOW_POWER_CONFIG_MASK;
                SAMPLE_RATE_DIVIDER_IDX: sample_rate_divider_r <= wb_dat_i[7:0];
                GYRO_BANDWIDTH_IDX: gyro_bandwidth_sel_r <= wb_dat_i[2:0];
                CTRL_IDX: ctrl_r <= wb_dat_i[1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Filter decode
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accel_filter_bypass_o <= 1'b0;
        end else begin
            accel_filter_bypass_o <= accel_filter_bypass;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accel_bw_dhz_o <= 16'h0000;
            accel_rate_hz_o <= 16'h0000;
        end else begin
            if (accel_filter_bypass) begin
                accel_bw_dhz_o <= 16'd10460;
                accel_rate_hz_o <= 16'd4000;
            end else begin
                accel_rate_hz_o <= 16'd1000;
                unique case (accel_bandwidth_sel)
                    3'd0, 3'd1: accel_bw_dhz_o <= 16'd2181;
                    3'd2: accel_bw_dhz_o <= 16'd990;
                    3'd3: accel_bw_dhz_o <= 16'd448;
                    3'd4: accel_bw_dhz_o <= 16'd212;
                    3'd5: accel_bw_dhz_o <= 16'd102;
                    3'd6: accel_bw_dhz_o <= 16'd51;
                    3'd7: accel_bw_dhz_o <= 16'd4200;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Averaging depth
    // ----------------------------------------------------------------
    // In averaged low-power mode the averaging depth applies; bypass means one sample.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accel_avg_samples_o <= 6'h01;
        end else if (accel_lp && !accel_filter_bypass
            && accel_bandwidth_sel == ACCEL_BW_AVG_CODE) begin
            accel_avg_samples_o <= 6'h04 << accel_avg_depth;
        end else begin
            accel_avg_samples_o <= 6'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gyro_cycle_o <= 1'b0;
        end else begin
            gyro_cycle_o <= gyro_low_power_config_r[GYRO_CYCLE_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gyro_avg_samples_o <= 8'h01;
        end else if (gyro_low_power_config_r[GYRO_CYCLE_BIT]) begin
            gyro_avg_samples_o <= 8'h01 << gyro_avg_depth;
        end else begin
            gyro_avg_samples_o <= 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gyro_bandwidth_sel_o <= 3'h0;
        end else begin
            gyro_bandwidth_sel_o <= gyro_bandwidth_sel_r;
        end
    end

    // ----------------------------------------------------------------
    // Base tick and output rate
    // ----------------------------------------------------------------
    logic [16:0] base_cnt_r;
    logic base_tick;
    logic odr_nxt;

    assign base_tick = run && (base_cnt_r == 17'(BASE_TICK_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i || !run || base_tick) begin
            base_cnt_r <= 17'd0;
        end else begin
            base_cnt_r <= base_cnt_r + 17'd1;
        end
    end

    rate_divider u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .div_i(sample_rate_divider_r),
        .tick_i(base_tick),
        .strobe_o(odr_nxt)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            odr_strobe_o <= 1'b0;
        end else begin
            odr_strobe_o <= odr_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Duty cycling: on-time counted from each output strobe.
    // ----------------------------------------------------------------
    logic [TON_W-1:0] accel_ton_nxt;
    logic [TON_W-1:0] gyro_ton_nxt;
    logic [TON_W-1:0] accel_cnt_r;
    logic [TON_W-1:0] gyro_cnt_r;
    logic [TON_W-1:0] gyro_us;

    always_comb begin
        accel_ton_nxt = TON_W'(ACCEL_TON_1X_US * CYC_PER_US);
        if (accel_avg_samples_o != 6'd1) begin
            unique case (accel_avg_depth)
                2'd0: accel_ton_nxt = TON_W'(ACCEL_TON_4X_US * CYC_PER_US);
                2'd1: accel_ton_nxt = TON_W'(ACCEL_TON_8X_US * CYC_PER_US);
                2'd2: accel_ton_nxt = TON_W'(ACCEL_TON_16X_US * CYC_PER_US);
                2'd3: accel_ton_nxt = TON_W'(ACCEL_TON_32X_US * CYC_PER_US);
            endcase
        end
    end

    // Gyro on-time is 1.73 ms plus 0.5 ms per extra sample: 1.73 .. 65.23 ms.
    always_comb begin
        gyro_us = TON_W'(GYRO_TON_1X_US)
            + TON_W'(GYRO_TON_STEP_US) * (TON_W'(gyro_avg_samples_o) - TON_W'(1));
        gyro_ton_nxt = TON_W'(gyro_us * TON_W'(CYC_PER_US));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !accel_lp) begin
            accel_cnt_r <= '0;
        end else if (odr_strobe_o) begin
            accel_cnt_r <= accel_ton_nxt;
        end else if (accel_cnt_r != '0) begin
            accel_cnt_r <= accel_cnt_r - TON_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !gyro_cycle_o) begin
            gyro_cnt_r <= '0;
        end else if (odr_strobe_o) begin
            gyro_cnt_r <= gyro_ton_nxt;
        end else if (gyro_cnt_r != '0) begin
            gyro_cnt_r <= gyro_cnt_r - TON_W'(1);
        end
    end

    // Outside low-power mode the sensor stays on while running.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accel_on_o <= 1'b0;
        end else begin
            accel_on_o <= accel_lp ? (accel_cnt_r != '0) : run;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gyro_on_o <= 1'b0;
        end else begin
            gyro_on_o <= gyro_cycle_o ? (gyro_cnt_r != '0) : run;
        end
    end
endmodule

// file: test/filt_cfg_props.sv
// Purpose: Port assertions for the filter and low-power configuration block.
// Assumes: One clock, synchronous active-high reset, classic Wishbone slave.
// Notes: Attached to the top module by the bind below the module.
`timescale 1ns/1ns
module filt_cfg_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // Settings
    input wire logic accel_filter_bypass_o,
    input wire logic [15:0] accel_bw_dhz_o,
    input wire logic [15:0] accel_rate_hz_o,
    input wire logic [5:0] accel_avg_samples_o,
    input wire logic gyro_cycle_o,
    input wire logic [7:0] gyro_avg_samples_o
);
    import filt_cfg_pkg::*;
    logic req;
    logic rd;
    logic mapped;
    logic [7:0] idx;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    assign idx = wb_adr_i[9:2];
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign rd = wb_ack_o && !wb_we_i;
    assign mapped = idx inside {ACCEL_FILTER_CONFIG_IDX, GYRO_LOW_POWER_CONFIG_IDX,
        SAMPLE_RATE_DIVIDER_IDX, GYRO_BANDWIDTH_IDX, CTRL_IDX, STATUS_IDX};
    a_bus_answer: assert property (req |=> wb_ack_o != wb_err_o)
        else $error("request not answered once");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
        else $error("answer without request");
    a_err_unmapped: assert property (req |=> wb_err_o == !mapped)
        else $error("error flag wrong for address");
    a_accel_mask: assert property (rd && idx == ACCEL_FILTER_CONFIG_IDX |->
        wb_dat_o[31:6] == '0) else $error("accel config reserved bits set");
    a_gyro_mask: assert property (rd && idx == GYRO_LOW_POWER_CONFIG_IDX |->
        wb_dat_o[31:8] == '0 && wb_dat_o[3:0] == '0) else $error("gyro reserved bits set");
    a_bypass_wide: assert property (accel_filter_bypass_o |->
        accel_rate_hz_o == 16'h0fa0 && accel_bw_dhz_o == 16'h28dc) else $error("bypass decode");
    a_lowpass_rate: assert property (!accel_filter_bypass_o && accel_rate_hz_o != 0 |->
        accel_rate_hz_o == 16'h03e8) else $error("filtered rate wrong");
    a_bypass_single: assert property (accel_filter_bypass_o |->
        accel_avg_samples_o == 6'h01) else $error("bypass with averaging");
    a_accel_legal: assert property ($onehot(accel_avg_samples_o) &&
        !accel_avg_samples_o[1]) else $error("accel average depth illegal");
    a_gyro_idle: assert property (!gyro_cycle_o |-> gyro_avg_samples_o == 8'h01)
        else $error("gyro averages while not cycling");
    a_gyro_onehot: assert property ($onehot(gyro_avg_samples_o))
        else $error("gyro average depth illegal");
    c_write: cover property (wb_ack_o && wb_we_i);
    c_err: cover property (wb_err_o);
    c_acc32: cover property (accel_avg_samples_o == 6'h20);
    c_gyr128: cover property (gyro_avg_samples_o == 8'h80);
endmodule
bind accel_gyro_filter_lowpower_cfg filt_cfg_props i_props (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .accel_filter_bypass_o,
    .accel_bw_dhz_o, .accel_rate_hz_o, .accel_avg_samples_o, .gyro_cycle_o,
    .gyro_avg_samples_o);

// file: test/tb_accel_gyro_filter_lowpower_cfg.sv
// Purpose: Self-checking bench for the filter configuration block.
// Assumes: Bus answers are compared by a monitor against queued notes.
// Notes: Base ticks and on-times lie beyond the run length and are not reached.
`timescale 1ns/1ns
module tb_accel_gyro_filter_lowpower_cfg;
    import filt_cfg_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [9:0] adr = '0;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat = '0, dat_o, r, seed = 32'h0000_0038;
    logic ack, err, byp, gcyc, gon, aon, odr;
    logic [15:0] bw, rate;
    logic [5:0] aavg;
    logic [7:0] gavg;
    logic [2:0] gbw;
    logic [33:0] q[$], e;
    logic [15:0] bwt[8] = '{16'h0885, 16'h0885, 16'h03de, 16'h01c0, 16'h00d4, 16'h0066,
        16'h0033, 16'h1068};
    int fail_count = 0, samples_checked = 0;
    accel_gyro_filter_lowpower_cfg i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err), .accel_filter_bypass_o(byp),
        .accel_bw_dhz_o(bw), .accel_rate_hz_o(rate), .accel_avg_samples_o(aavg),
        .accel_on_o(aon), .gyro_cycle_o(gcyc), .gyro_avg_samples_o(gavg),
        .gyro_bandwidth_sel_o(gbw), .gyro_on_o(gon), .odr_strobe_o(odr));
    initial forever #4 clk_i = ~clk_i;
    function automatic logic [31:0] xs;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        if (fail_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Bus cycles; the note holds {check data, error, data}.
    // ------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] i, input logic [31:0] d,
        input logic [33:0] n);
        int k;
        k = 0;
        @(posedge clk_i);
        q.push_back(n);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {i, 2'b00};
        dat <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (!(ack || err) && k < 20);
        if (!(ack || err)) begin
            fail_count++;
            test_done();
        end
        cyc <= 0;
        stb <= 0;
        @(negedge clk_i);
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        wb(1, i, d, {2'b00, 32'h0});
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] v);
        wb(0, i, 0, {2'b10, v});
    endtask
    always @(negedge clk_i) begin
        if (ack || err) begin
            e = q.size() ? q.pop_front() : '1;
            chk(32'(err), 32'(e[32]));
            if (e[33]) chk(dat_o, e[31:0]);
        end
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        fail_count++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        @(negedge clk_i);
        chk({23'h0, gcyc, gavg}, 32'h0000_0001);
        rd(ACCEL_FILTER_CONFIG_IDX, 0);
        rd(GYRO_LOW_POWER_CONFIG_IDX, 0);
        wr(ACCEL_FILTER_CONFIG_IDX, 32'hffff_ffff);
        rd(ACCEL_FILTER_CONFIG_IDX, 32'h0000_003f);
        chk({rate, bw}, 32'h0fa0_28dc);
        chk({26'h0, aavg}, 32'h0000_0001);
        wr(GYRO_LOW_POWER_CONFIG_IDX, 32'hffff_ffff);
        rd(GYRO_LOW_POWER_CONFIG_IDX, 32'h0000_00f0);
        chk({23'h0, gcyc, gavg}, 32'h0000_0180);
        for (int i = 0; i < 8; i++) begin
            wr(ACCEL_FILTER_CONFIG_IDX, 32'(i));
            chk({rate, bw}, {16'h03e8, bwt[i]});
        end
        wr(CTRL_IDX, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            wr(ACCEL_FILTER_CONFIG_IDX, 32'(i * 16 + 7));
            chk({26'h0, aavg}, 32'h0000_0004 << i);
            wr(ACCEL_FILTER_CONFIG_IDX, 32'(i * 16 + 14));
            chk({26'h0, aavg}, 32'h0000_0001);
        end
        for (int i = 0; i < 8; i++) begin
            r = xs();
            wr(GYRO_BANDWIDTH_IDX, r);
            wr(GYRO_LOW_POWER_CONFIG_IDX, 32'(128 + i * 16));
            chk({23'h0, gcyc, gavg}, 32'h0000_0100 | (32'h0000_0001 << i));
            chk({29'h0, gbw}, {29'h0, r[2:0]});
            wr(GYRO_LOW_POWER_CONFIG_IDX, 32'(i * 16));
            chk({23'h0, gcyc, gavg}, 32'h0000_0001);
        end
        wr(CTRL_IDX, 32'hffff_fffe);
        rd(CTRL_IDX, 32'h0000_0002);
        rd(STATUS_IDX, 32'h0000_0003);
        chk({29'h0, odr, gon, aon}, 32'h0000_0003);
        wr(CTRL_IDX, 32'h0000_0003);
        wr(GYRO_LOW_POWER_CONFIG_IDX, 32'h0000_0080);
        rd(STATUS_IDX, 32'h0000_0000);
        @(posedge clk_i);
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        @(negedge clk_i);
        chk({23'h0, gcyc, gavg}, 32'h0000_0001);
        chk({29'h0, odr, gon, aon}, 32'h0000_0000);
        rd(GYRO_LOW_POWER_CONFIG_IDX, 0);
        rd(CTRL_IDX, 0);
        r = xs();
        wr(SAMPLE_RATE_DIVIDER_IDX, r);
        @(posedge clk_i);
        sel <= 4'he;
        wr(SAMPLE_RATE_DIVIDER_IDX, ~r);
        @(posedge clk_i);
        sel <= 4'hf;
        rd(SAMPLE_RATE_DIVIDER_IDX, {24'h0, r[7:0]});
        wb(1, 8'h22, r, {2'b01, 32'h0});
        wb(0, 8'h22, 0, {2'b01, 32'h0});
        test_done();
    end
endmodule
